// [mcd_frame_rx.sv]
`timescale 1ns/10ps

// gathers nine bytes into one frame and checks its sum
module mcd_frame_rx
(
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// byte stream
	input  wire logic               byte_valid_i,
	input  wire logic [7:0]         byte_data_i,
	// assembled frame
	output mcd_pkg::mcd_frame_type  frame_o,
	output logic                    frame_valid_o,
	output logic                    csum_ok_o
);

	logic [3:0]             count_reg,  count_next;
	logic [7:0]             sum_reg,    sum_next;
	mcd_pkg::mcd_frame_type frame_reg,  frame_next;
	logic                   valid_reg,  valid_next;
	logic                   ok_reg,     ok_next;

	// byte counter, shift-in and running sum
	always_comb
	begin
		count_next = count_reg;
		sum_next   = sum_reg;
		frame_next = frame_reg;
		valid_next = 1'b0;
		ok_next    = ok_reg;
		if (byte_valid_i)
		begin
			// bytes arrive in frame order, so shift in from the low end
			frame_next = {frame_reg[63:0], byte_data_i};
			if (count_reg == mcd_pkg::IDX_CSUM)
			begin
				count_next = 4'h0;
				sum_next   = 8'h00;
				valid_next = 1'b1;
				ok_next    = (sum_reg == byte_data_i);
			end
			else
			begin
				count_next = count_reg + 4'h1;
				sum_next   = sum_reg + byte_data_i; // modulo 256 by width
			end
		end
	end

	// registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			count_reg <= 4'h0;
			sum_reg   <= 8'h00;
			frame_reg <= '0;
			valid_reg <= 1'b0;
			ok_reg    <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			sum_reg   <= sum_next;
			frame_reg <= frame_next;
			valid_reg <= valid_next;
			ok_reg    <= ok_next;
		end
	end

	assign frame_o       = frame_reg;
	assign frame_valid_o = valid_reg;
	assign csum_ok_o     = ok_reg;

endmodule : mcd_frame_rx

// [mcd_host_model.sv]
`timescale 1ns/10ps

// host side: sends command frames byte by byte with random gaps
module mcd_host_model
(
	// clock
	input  wire logic  clk_i,
	// byte stream to the decoder
	output logic       valid_o,
	output logic [7:0] data_o
);
	// idle start values
	initial
	begin
		valid_o = 1'b0;
		data_o = 8'h00;
	end

	// one frame; idle line inverts so a stale byte is never reused
	task automatic send(input logic [7:0] ad, ins, ty, bk, input logic [31:0] val, input bit bad);
		logic [7:0] b[9];
		b = '{ad, ins, ty, bk, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
		for (int i = 0; i < 8; i++)
			b[8] = b[8] + b[i];
		b[8] = b[8] + {7'h00, bad};
		for (int i = 0; i < 9; i++)
		begin
			valid_o <= 1'b1;
			data_o <= b[i];
			@(posedge clk_i);
			repeat ($urandom_range(2))
			begin
				valid_o <= 1'b0;
				data_o <= ~data_o;
				@(posedge clk_i);
			end
		end
		valid_o <= 1'b0;
		data_o <= ~data_o;
		@(posedge clk_i);
	endtask : send
endmodule : mcd_host_model

// [mcd_motion_decoder.sv]
`timescale 1ns/10ps

// Overview of operation
// - rotate-positive selects velocity mode and loads velocity, clamped to VEL_LIMIT, as target velocity in the same cycle.
// - rotate-negative selects velocity mode, loads velocity clamped to VEL_LIMIT so position decreases.
// - rotate-positive is code 01h, rotate-negative 02h, type and bank zero.
// - soft stop, code 03h, selects velocity mode and zero target speed.
// - frame: address, instruction, type, bank, value MSB first, checksum.
// - motion commands reply status 100; reply value is meaningless.
// - move-to-position, code 4, uses the ramp and speed already held.
// - move does not block; reply at once, later commands still accepted.
// - position targets are signed 32-bit, negatives in two's complement.
// - stop or rotate commands override a move in progress.
// - type 0 absolute, 1 relative to actual, 2 stored coordinate.
// - distances past 2^31-1 wrap and run the shorter opposite way.
// - move writes the resolved position into target position.
// - relative minus 10000 is FF FF D8 F0 with type 01h.
// - axis settings live in volatile flip-flops, lost at power off.
module mcd_motion_decoder
(
	// clock and reset
	input  wire logic                 CLOCK_I,
	input  wire logic                 RST_I,
	// received byte stream
	input  wire logic                 RX_VALID_I,
	input  wire logic [7:0]           RX_DATA_I,
	// motion controller state
	input  wire logic signed [31:0]   ACTUAL_POSITION_I,
	// stored coordinate load port
	input  wire logic                 MOVE_TYPE_STORED_POINT_WRITE_I,
	input  wire logic [4:0]           MOVE_TYPE_STORED_POINT_INDEX_I,
	input  wire logic signed [31:0]   MOVE_TYPE_STORED_POINT_DATA_I,
	// motion controller settings
	output mcd_pkg::mcd_motion_type   MOTION_O,
	output logic                      MOTION_LOAD_O,
	// reply
	output mcd_pkg::mcd_reply_type    REPLY_O,
	output logic                      REPLY_VALID_O
);

	mcd_pkg::mcd_frame_type frame;
	logic                   frame_valid;
	logic                   csum_ok;

	// frame assembly and checksum
	mcd_frame_rx u_rx
	(
		.clk_i         (CLOCK_I),
		.rst_i         (RST_I),
		.byte_valid_i  (RX_VALID_I),
		.byte_data_i   (RX_DATA_I),
		.frame_o       (frame),
		.frame_valid_o (frame_valid),
		.csum_ok_o     (csum_ok)
	);

	// stored coordinates, volatile
	logic signed [31:0] move_type_stored_point_reg [mcd_pkg::MOVE_TYPE_STORED_POINT_COUNT];
	logic signed [31:0] move_type_stored_point_next [mcd_pkg::MOVE_TYPE_STORED_POINT_COUNT];

	// one write path per coordinate entry
	genvar gi;
	generate
		for (gi = 0; gi < mcd_pkg::MOVE_TYPE_STORED_POINT_COUNT; gi++)
		begin : g_move_type_stored_point
			always_comb
			begin
				move_type_stored_point_next[gi] = move_type_stored_point_reg[gi];
				if (MOVE_TYPE_STORED_POINT_WRITE_I && (MOVE_TYPE_STORED_POINT_INDEX_I == 5'(gi)))
				begin
					move_type_stored_point_next[gi] = MOVE_TYPE_STORED_POINT_DATA_I;
				end
			end

			always_ff @(posedge CLOCK_I)
			begin
				if (RST_I)
				begin
					move_type_stored_point_reg[gi] <= mcd_pkg::RESET_POSITION;
				end
				else
				begin
					move_type_stored_point_reg[gi] <= move_type_stored_point_next[gi];
				end
			end
		end
	endgenerate

	mcd_pkg::mcd_motion_type motion_reg, motion_next;
	logic                    load_reg,   load_next;
	mcd_pkg::mcd_reply_type  reply_reg,  reply_next;
	logic                    rvalid_reg, rvalid_next;

	logic signed [31:0] vel;
	logic signed [31:0] vel_clamped;
	logic signed [31:0] pos;
	logic               zero_fields;
	logic [4:0]         move_type_stored_point_sel;
	logic               move_type_stored_point_bad;

	// velocity clamp, signed
	always_comb
	begin
		vel = $signed(frame.value);
		vel_clamped = vel;
		if (vel > $signed(mcd_pkg::VEL_LIMIT))
		begin
			vel_clamped = $signed(mcd_pkg::VEL_LIMIT);
		end
		else if (vel < -$signed(mcd_pkg::VEL_LIMIT))
		begin
			vel_clamped = -$signed(mcd_pkg::VEL_LIMIT);
		end
	end

	// stored-point index; past the last entry it reads entry 0, and the frame is refused
	always_comb
	begin
		move_type_stored_point_bad = (frame.value > mcd_pkg::MOVE_TYPE_STORED_POINT_LAST);
		move_type_stored_point_sel = frame.value[4:0];
		if (move_type_stored_point_bad)
		begin
			move_type_stored_point_sel = 5'h00;
		end
	end

	// target resolution; 32-bit add wraps on purpose so overlong moves go short way
	always_comb
	begin
		pos       = $signed(frame.value);
		case (frame.mtype)
			mcd_pkg::MOVE_TYPE_ABSOLUTE:     pos = $signed(frame.value);
			mcd_pkg::MOVE_TYPE_RELATIVE:     pos = ACTUAL_POSITION_I + $signed(frame.value);
			mcd_pkg::MOVE_TYPE_STORED_POINT: pos = move_type_stored_point_reg[move_type_stored_point_sel];
			default:                         pos = $signed(frame.value);
		endcase
	end

	assign zero_fields = (frame.mtype == 8'h00) && (frame.bank == 8'h00);

	// command classes; deciding the class first keeps the action logic flat
	typedef enum logic [3:0]
	{
		MCD_CMD_NONE,
		MCD_CMD_ROTATE_POS,
		MCD_CMD_ROTATE_NEG,
		MCD_CMD_STOP,
		MCD_CMD_MOVE,
		MCD_CMD_BAD_CSUM,
		MCD_CMD_BAD_CMD,
		MCD_CMD_BAD_TYPE,
		MCD_CMD_BAD_VALUE
	} mcd_cmd_type;

	// class of the frame completed in this cycle
	mcd_cmd_type cmd_class;

	// classify a completed frame; frames for other modules stay unanswered
	always_comb
	begin
		cmd_class = MCD_CMD_NONE;
		if (frame_valid && (frame.addr == mcd_pkg::MODULE_ADDR))
		begin
			if (!csum_ok)
			begin
				cmd_class = MCD_CMD_BAD_CSUM;
			end
			else
			begin
				case (frame.instr)
					mcd_pkg::ROTATE_POSITIVE_CMD:
					begin
						cmd_class = zero_fields ? MCD_CMD_ROTATE_POS : MCD_CMD_BAD_TYPE;
					end
					mcd_pkg::ROTATE_NEGATIVE_CMD:
					begin
						cmd_class = zero_fields ? MCD_CMD_ROTATE_NEG : MCD_CMD_BAD_TYPE;
					end
					mcd_pkg::SOFT_STOP_CMD:
					begin
						cmd_class = zero_fields ? MCD_CMD_STOP : MCD_CMD_BAD_TYPE;
					end
					mcd_pkg::MOVE_TO_POSITION_CMD:
					begin
						if (frame.mtype > mcd_pkg::MOVE_TYPE_STORED_POINT)
						begin
							cmd_class = MCD_CMD_BAD_TYPE;
						end
						else if ((frame.mtype == mcd_pkg::MOVE_TYPE_STORED_POINT) && move_type_stored_point_bad)
						begin
							cmd_class = MCD_CMD_BAD_VALUE;
						end
						else
						begin
							cmd_class = MCD_CMD_MOVE;
						end
					end
					default:
					begin
						cmd_class = MCD_CMD_BAD_CMD;
					end
				endcase
			end
		end
	end

	// command interpretation; every frame is handled the cycle it completes
	always_comb
	begin
		motion_next = motion_reg;
		load_next   = 1'b0;
		reply_next  = reply_reg;
		rvalid_next = 1'b0;
		if (cmd_class != MCD_CMD_NONE)
		begin
			rvalid_next       = 1'b1;
			reply_next.addr   = mcd_pkg::MODULE_ADDR;
			reply_next.instr  = frame.instr;
			reply_next.value  = 32'h0000_0000;
			reply_next.status = mcd_pkg::STATUS_OK;
		end
		case (cmd_class)
			MCD_CMD_ROTATE_POS:
			begin
				// mode and velocity load together; a move in progress is replaced
				motion_next.mode            = mcd_pkg::MCD_MODE_VELOCITY;
				motion_next.target_velocity = vel_clamped;
				load_next                   = 1'b1;
			end
			MCD_CMD_ROTATE_NEG:
			begin
				motion_next.mode            = mcd_pkg::MCD_MODE_VELOCITY;
				motion_next.target_velocity = -vel_clamped;
				load_next                   = 1'b1;
			end
			MCD_CMD_STOP:
			begin
				motion_next.mode            = mcd_pkg::MCD_MODE_VELOCITY;
				motion_next.target_velocity = mcd_pkg::RESET_VELOCITY;
				load_next                   = 1'b1;
			end
			MCD_CMD_MOVE:
			begin
				// ramp and speed stay in the controller; only mode and target change
				motion_next.mode            = mcd_pkg::MCD_MODE_POSITION;
				motion_next.target_position = pos;
				load_next                   = 1'b1;
			end
			// refused frames: status only, settings untouched
			MCD_CMD_BAD_CSUM:
			begin
				reply_next.status = mcd_pkg::STATUS_BAD_CSUM;
			end
			MCD_CMD_BAD_CMD:
			begin
				reply_next.status = mcd_pkg::STATUS_BAD_CMD;
			end
			MCD_CMD_BAD_TYPE:
			begin
				reply_next.status = mcd_pkg::STATUS_BAD_TYPE;
			end
			MCD_CMD_BAD_VALUE:
			begin
				reply_next.status = mcd_pkg::STATUS_BAD_VALUE;
			end
			default:
			begin
				load_next = 1'b0;
			end
		endcase
	end

	// registers, volatile by construction
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			motion_reg.mode            <= mcd_pkg::MCD_MODE_VELOCITY;
			motion_reg.target_velocity <= mcd_pkg::RESET_VELOCITY;
			motion_reg.target_position <= mcd_pkg::RESET_POSITION;
			load_reg                   <= 1'b0;
			reply_reg                  <= '0;
			rvalid_reg                 <= 1'b0;
		end
		else
		begin
			motion_reg <= motion_next;
			load_reg   <= load_next;
			reply_reg  <= reply_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// outputs straight from flip-flops
	assign MOTION_O      = motion_reg;
	assign MOTION_LOAD_O = load_reg;
	assign REPLY_O       = reply_reg;
	assign REPLY_VALID_O = rvalid_reg;

endmodule : mcd_motion_decoder

// [mcd_pkg.sv]
package mcd_pkg;

	// frame layout: address, instruction, type, bank, value[31:0], checksum
	localparam int          FRAME_BYTES     = 9;
	localparam logic [3:0]  IDX_ADDR        = 4'h0;
	localparam logic [3:0]  IDX_INSTR       = 4'h1;
	localparam logic [3:0]  IDX_TYPE        = 4'h2;
	localparam logic [3:0]  IDX_BANK        = 4'h3;
	localparam logic [3:0]  IDX_VAL3        = 4'h4;
	localparam logic [3:0]  IDX_CSUM        = 4'h8;

	// instruction codes
	localparam logic [7:0]  ROTATE_POSITIVE_CMD = 8'h01;
	localparam logic [7:0]  ROTATE_NEGATIVE_CMD = 8'h02;
	localparam logic [7:0]  SOFT_STOP_CMD       = 8'h03;
	localparam logic [7:0]  MOVE_TO_POSITION_CMD = 8'h04;

	// move type field
	localparam logic [7:0]  MOVE_TYPE_ABSOLUTE     = 8'h00;
	localparam logic [7:0]  MOVE_TYPE_RELATIVE     = 8'h01;
	localparam logic [7:0]  MOVE_TYPE_STORED_POINT = 8'h02;

	// reply status codes
	localparam logic [7:0]  STATUS_OK        = 8'h64;
	localparam logic [7:0]  STATUS_BAD_CSUM  = 8'h01;
	localparam logic [7:0]  STATUS_BAD_CMD   = 8'h02;
	localparam logic [7:0]  STATUS_BAD_TYPE  = 8'h03;
	localparam logic [7:0]  STATUS_BAD_VALUE = 8'h04;

	// device address and limits; address value is arbitrary
	localparam logic [7:0]  MODULE_ADDR      = 8'h01;
	localparam logic [31:0] VEL_LIMIT        = 32'h0000_07FF;
	localparam int          MOVE_TYPE_STORED_POINT_COUNT      = 21;
	localparam logic [31:0] MOVE_TYPE_STORED_POINT_LAST       = 32'h0000_0014;

	// reset values
	localparam logic [31:0] RESET_POSITION   = 32'h0000_0000;
	localparam logic [31:0] RESET_VELOCITY   = 32'h0000_0000;

	// motion controller modes
	typedef enum logic [1:0]
	{
		MCD_MODE_POSITION = 2'b00,
		MCD_MODE_VELOCITY = 2'b01
	} mcd_mode_type;

	// one complete received frame
	typedef struct packed
	{
		logic [7:0]  addr;
		logic [7:0]  instr;
		logic [7:0]  mtype;
		logic [7:0]  bank;
		logic [31:0] value;
		logic [7:0]  csum;
	} mcd_frame_type;

	// reply to the host
	typedef struct packed
	{
		logic [7:0]  addr;
		logic [7:0]  status;
		logic [7:0]  instr;
		logic [31:0] value;
	} mcd_reply_type;

	// settings handed to the motion controller
	typedef struct packed
	{
		mcd_mode_type       mode;
		logic signed [31:0] target_velocity;
		logic signed [31:0] target_position;
	} mcd_motion_type;

endpackage : mcd_pkg

// [mcd_props.sv]
`timescale 1ns/10ps

// relations between the decoder's reply and the settings it loads
module mcd_props
(
	// clock and reset
	input  wire logic                    CLOCK_I,
	input  wire logic                    RST_I,
	// observed outputs
	input  wire mcd_pkg::mcd_motion_type MOTION_O,
	input  wire logic                    MOTION_LOAD_O,
	input  wire mcd_pkg::mcd_reply_type  REPLY_O,
	input  wire logic                    REPLY_VALID_O
);
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (RST_I);

	// a load never comes without its reply, and only as a success
	a_load_has_reply: assert property (MOTION_LOAD_O |-> REPLY_VALID_O)
		else $error("motion load without reply");
	a_load_status_ok: assert property (MOTION_LOAD_O |-> REPLY_O.status == mcd_pkg::STATUS_OK)
		else $error("motion load with failing status");
	a_rotate_vel_mode: assert property (MOTION_LOAD_O
		&& REPLY_O.instr != mcd_pkg::MOVE_TO_POSITION_CMD
		|-> MOTION_O.mode == mcd_pkg::MCD_MODE_VELOCITY)
		else $error("rotate or stop left velocity mode off");
	a_stop_zero_vel: assert property (MOTION_LOAD_O && REPLY_O.instr == mcd_pkg::SOFT_STOP_CMD
		|-> MOTION_O.target_velocity == 32'h0000_0000)
		else $error("soft stop kept a speed");
	a_move_pos_mode: assert property (MOTION_LOAD_O
		&& REPLY_O.instr == mcd_pkg::MOVE_TO_POSITION_CMD
		|-> MOTION_O.mode == mcd_pkg::MCD_MODE_POSITION)
		else $error("move did not select position mode");
	a_vel_in_limit: assert property (MOTION_LOAD_O
		|-> $signed(MOTION_O.target_velocity) <= $signed(mcd_pkg::VEL_LIMIT)
		&& $signed(MOTION_O.target_velocity) >= -$signed(mcd_pkg::VEL_LIMIT))
		else $error("target velocity beyond limit");
	// settings and reply only change together with their pulses
	a_motion_hold: assert property (!MOTION_LOAD_O |-> $stable(MOTION_O))
		else $error("settings changed without load");
	a_reply_hold: assert property (!REPLY_VALID_O |-> $stable(REPLY_O))
		else $error("reply changed without valid");
	// nine bytes per frame keep replies at least nine cycles apart
	a_reply_spacing: assert property (REPLY_VALID_O |=> !REPLY_VALID_O [*8])
		else $error("replies closer than one frame");

	cover property (MOTION_LOAD_O && REPLY_O.instr == mcd_pkg::MOVE_TO_POSITION_CMD);
	cover property (MOTION_LOAD_O && REPLY_O.instr == mcd_pkg::ROTATE_NEGATIVE_CMD);
	cover property (REPLY_VALID_O && REPLY_O.status == mcd_pkg::STATUS_BAD_CSUM);
endmodule : mcd_props

bind mcd_motion_decoder mcd_props chk_u
(
	.CLOCK_I       (CLOCK_I),
	.RST_I         (RST_I),
	.MOTION_O      (MOTION_O),
	.MOTION_LOAD_O (MOTION_LOAD_O),
	.REPLY_O       (REPLY_O),
	.REPLY_VALID_O (REPLY_VALID_O)
);

// [tb_top.sv]
`timescale 1ns/10ps

// drives command frames into the decoder and scores every reply
module tb_top;
	typedef struct
	{
		logic [7:0]  st;
		logic [7:0]  ins;
		logic        ld;
		logic [1:0]  md;
		logic [31:0] vel;
		logic [31:0] pos;
		logic        cv;
		logic        cp;
	} mcd_exp_type;

	logic                    clock_i;
	logic                    rst_i;
	logic                    rx_valid;
	logic [7:0]              rx_data;
	logic signed [31:0]      act_pos;
	logic                    move_type_stored_point_wr;
	logic [4:0]              move_type_stored_point_idx;
	logic signed [31:0]      move_type_stored_point_dat;
	mcd_pkg::mcd_motion_type motion;
	logic                    motion_load;
	mcd_pkg::mcd_reply_type  reply;
	logic                    reply_valid;
	mcd_exp_type             exp_q[$];
	mcd_exp_type             cur;
	logic signed [31:0]      v;
	logic [31:0]             last_pos;
	int                      err_total;
	int                      n_tests;

	mcd_motion_decoder dut_u
	(
		.CLOCK_I(clock_i), .RST_I(rst_i), .RX_VALID_I(rx_valid), .RX_DATA_I(rx_data),
		.ACTUAL_POSITION_I(act_pos), .MOVE_TYPE_STORED_POINT_WRITE_I(move_type_stored_point_wr), .MOVE_TYPE_STORED_POINT_INDEX_I(move_type_stored_point_idx),
		.MOVE_TYPE_STORED_POINT_DATA_I(move_type_stored_point_dat), .MOTION_O(motion), .MOTION_LOAD_O(motion_load),
		.REPLY_O(reply), .REPLY_VALID_O(reply_valid)
	);
	mcd_host_model host_u (.clk_i(clock_i), .valid_o(rx_valid), .data_o(rx_data));

	// clock
	initial
	begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : check

	task automatic report_and_stop();
		$display("errors %0d checks %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	function automatic logic signed [31:0] clamp(input logic signed [31:0] x);
		if (x > $signed(mcd_pkg::VEL_LIMIT))
			return $signed(mcd_pkg::VEL_LIMIT);
		if (x < -$signed(mcd_pkg::VEL_LIMIT))
			return -$signed(mcd_pkg::VEL_LIMIT);
		return x;
	endfunction : clamp

	task automatic exp_add(input logic [7:0] st, ins, input logic ld, input logic [1:0] md,
		input logic [31:0] vel, pos, input logic cv, cp);
		exp_q.push_back('{st, ins, ld, md, vel, pos, cv, cp});
	endtask : exp_add

	// rotate or stop; only a stop promises to keep the target position
	task automatic rot(input logic [7:0] ins, input logic signed [31:0] val);
		logic signed [31:0] e;
		e = (ins == mcd_pkg::SOFT_STOP_CMD) ? 32'sh0000_0000 : clamp(val);
		if (ins == mcd_pkg::ROTATE_NEGATIVE_CMD)
			e = -e;
		exp_add(mcd_pkg::STATUS_OK, ins, 1'b1, mcd_pkg::MCD_MODE_VELOCITY, e, last_pos, 1'b1,
			ins == mcd_pkg::SOFT_STOP_CMD);
		host_u.send(mcd_pkg::MODULE_ADDR, ins, 8'h00, 8'h00, val, 1'b0);
	endtask : rot

	task automatic move_to_position_cmd(input logic [7:0] ty, input logic [31:0] val, p);
		last_pos = p;
		exp_add(mcd_pkg::STATUS_OK, mcd_pkg::MOVE_TO_POSITION_CMD, 1'b1,
			mcd_pkg::MCD_MODE_POSITION, 32'h0000_0000, p, 1'b0, 1'b1);
		host_u.send(mcd_pkg::MODULE_ADDR, mcd_pkg::MOVE_TO_POSITION_CMD, ty, 8'h00, val, 1'b0);
	endtask : move_to_position_cmd

	// refused frame: error status, no load; foreign address gets no reply
	task automatic bad(input logic [7:0] ad, ins, ty, input logic [31:0] val, input bit cs,
		input logic [7:0] st);
		if (ad == mcd_pkg::MODULE_ADDR)
			exp_add(st, ins, 1'b0, 2'h0, 32'h0000_0000, 32'h0000_0000, 1'b0, 1'b0);
		host_u.send(ad, ins, ty, 8'h00, val, cs);
	endtask : bad

	// reply scoreboard
	always @(posedge clock_i)
	begin
		if (reply_valid === 1'b1)
		begin
			if (exp_q.size() == 0)
				check("unexpected reply", 32'h0000_0000, 32'h0000_0001);
			else
			begin
				cur = exp_q.pop_front();
				check("addr", 32'(mcd_pkg::MODULE_ADDR), 32'(reply.addr));
				check("status", 32'(cur.st), 32'(reply.status));
				check("value", 32'h0000_0000, reply.value);
				check("load", 32'(cur.ld), 32'(motion_load));
				check("instr", 32'(cur.ins), 32'(reply.instr));
				if (cur.ld)
					check("mode", 32'(cur.md), 32'(motion.mode));
				if (cur.cv)
					check("velocity", cur.vel, motion.target_velocity);
				if (cur.cp)
					check("position", cur.pos, motion.target_position);
			end
		end
	end

	// whole run is well under 2000 cycles
	initial
	begin
		#200000;
		err_total++;
		report_and_stop();
	end

	// main sequence
	initial
	begin
		void'($urandom(17));
		err_total = 0;
		n_tests = 0;
		last_pos = 32'h0000_0000;
		rst_i = 1'b1;
		act_pos = 32'sh0000_0000;
		move_type_stored_point_wr = 1'b0;
		move_type_stored_point_idx = 5'h00;
		move_type_stored_point_dat = 32'sh0000_0000;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		rot(mcd_pkg::ROTATE_POSITIVE_CMD, 32'sh0000_03E8);
		rot(mcd_pkg::ROTATE_NEGATIVE_CMD, 32'sh0000_03E8);
		repeat (4)
		begin
			v = $signed($urandom_range(8000)) - 32'sd4000;
			rot(mcd_pkg::ROTATE_POSITIVE_CMD, v);
			rot(mcd_pkg::ROTATE_NEGATIVE_CMD, v);
		end
		move_to_position_cmd(mcd_pkg::MOVE_TYPE_ABSOLUTE, 32'h0001_5F90, 32'h0001_5F90);
		rot(mcd_pkg::SOFT_STOP_CMD, 32'sh0000_0000);
		move_to_position_cmd(mcd_pkg::MOVE_TYPE_ABSOLUTE, 32'h8000_0000, 32'h8000_0000);
		v = $urandom_range(32'h3FFF_FFFF);
		act_pos <= v;
		move_to_position_cmd(mcd_pkg::MOVE_TYPE_RELATIVE, 32'hFFFF_D8F0, v - 32'sd10000);
		act_pos <= 32'sh7FFF_FFF0;
		move_to_position_cmd(mcd_pkg::MOVE_TYPE_ABSOLUTE, 32'h8000_0010, 32'h8000_0010);
		v = $urandom;
		move_type_stored_point_idx <= 5'h08;
		move_type_stored_point_dat <= v;
		move_type_stored_point_wr <= 1'b1;
		@(posedge clock_i);
		move_type_stored_point_wr <= 1'b0;
		move_to_position_cmd(mcd_pkg::MOVE_TYPE_STORED_POINT, 32'h0000_0008, v);
		rot(mcd_pkg::ROTATE_NEGATIVE_CMD, 32'sh0000_07FF);
		bad(mcd_pkg::MODULE_ADDR, 8'h01, 8'h00, 32'h0000_0010, 1'b1, mcd_pkg::STATUS_BAD_CSUM);
		bad(mcd_pkg::MODULE_ADDR, 8'h09, 8'h00, 32'h0000_0000, 1'b0, mcd_pkg::STATUS_BAD_CMD);
		bad(mcd_pkg::MODULE_ADDR, 8'h01, 8'h01, 32'h0000_0000, 1'b0, mcd_pkg::STATUS_BAD_TYPE);
		bad(mcd_pkg::MODULE_ADDR, 8'h04, 8'h03, 32'h0000_0000, 1'b0, mcd_pkg::STATUS_BAD_TYPE);
		bad(mcd_pkg::MODULE_ADDR, 8'h04, 8'h02, 32'h0000_0015, 1'b0, mcd_pkg::STATUS_BAD_VALUE);
		bad(8'h02, 8'h04, 8'h00, 32'h0000_1234, 1'b0, 8'h00);
		rot(mcd_pkg::SOFT_STOP_CMD, 32'sh0000_0000);
		for (int i = 0; i < 50 && exp_q.size() != 0; i++)
			@(posedge clock_i);
		repeat (20) @(posedge clock_i);
		check("replies left", 32'h0000_0000, 32'(exp_q.size()));
		report_and_stop();
	end
endmodule : tb_top
